// *** rtl/touch_key_pkg.sv ***
package touch_key_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [17:0] IDX_CONTROL = 18'h0a130;
  localparam logic [17:0] IDX_ANALOG = 18'h0a131;
  localparam logic [17:0] IDX_FILTER = 18'h0a132;
  localparam logic [17:0] IDX_THRESH = 18'h0a133;
  localparam logic [17:0] IDX_PERIOD = 18'h0a140;
  localparam logic [17:0] IDX_CAPTURE = 18'h0a144;
  localparam logic [17:0] IDX_SLOW = 18'h0a148;
  localparam logic [17:0] IDX_FAST = 18'h0a14c;
  localparam int ADDR_W = 20;
  localparam int VAL_W = 24;
  // Control register bit positions.
  localparam int CTL_START = 0;
  localparam int CTL_FLAG = 1;
  localparam int CTL_IRQ_EN = 2;
  localparam int CTL_AUTO = 3;
  localparam int CTL_CLK_LO = 4;
  localparam int CTL_MODE = 6;
  localparam int CTL_ENABLE = 7;
  // Threshold top byte bit positions.
  localparam int THR_ABS = 23;
  localparam int THR_DLY_LO = 21;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ANALOG_RESET = 8'h00;
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [7:0] PRBS_SEED = 8'hff;
  localparam logic [23:0] AUTO_MASK = 24'h00ffff;
  localparam int SLOW_SHIFT_BASE = 3;
  localparam int RATIO_SHIFT = 10;
  localparam logic [10:0] DELAY_64 = 11'h040;
  localparam logic [10:0] DELAY_256 = 11'h100;
  localparam logic [10:0] DELAY_512 = 11'h200;
  localparam logic [10:0] DELAY_1024 = 11'h400;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } sense_state_t;

  typedef struct packed {
    logic enable;
    logic mode;
    logic [1:0] clk_choice;
    logic auto_mode;
    logic irq_en;
  } ctrl_t;

  typedef struct packed {
    logic speed;
    logic random_en;
    logic multiplier;
    logic [3:0] step;
  } analog_t;
endpackage : touch_key_pkg

// *** rtl/touch_key_capacitance_sensor.sv ***
`timescale 1ns/1ps
module touch_key_capacitance_sensor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [touch_key_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front-end.
  input wire logic sense_osc,
  output touch_key_pkg::analog_t analog_setup,
  output logic current_double,
  output logic slow_osc_select,
  output logic analog_pin_enable,
  // Events.
  output logic touch_irq,
  output logic wake_event
);
  import touch_key_pkg::*;

  sense_state_t state_q;
  ctrl_t ctrl_q;
  analog_t analog_q;
  logic [7:0] filter_q;
  logic irq_flag_q;
  logic [23:0] thresh_q;
  logic [VAL_W-1:0] period_q;
  logic [VAL_W-1:0] timer_q;
  logic [VAL_W-1:0] counter_q;
  logic [VAL_W-1:0] capture_q;
  logic [VAL_W-1:0] slow_q;
  logic [VAL_W-1:0] fast_q;
  logic [7:0] prbs_q;
  logic [10:0] settle_q;
  logic [1:0] sense_sync_q;
  logic sense_last_q;
  logic wake_q;
  logic [31:0] prdata_q;

  logic [17:0] idx;
  logic wr_en;
  logic ctl_wr;
  logic start_cmd;
  logic abort_cmd;
  logic sense_tick;
  logic timer_tick;
  logic count_tick;
  logic expire;
  logic detect;
  logic [VAL_W-1:0] width_mask;
  logic [VAL_W-1:0] new_slow;
  logic [VAL_W-1:0] new_fast;
  logic [VAL_W-1:0] thr_val;
  logic [10:0] delay_need;

  // Byte-wide register slice of a 24-bit field.
  function automatic logic [23:0] put_byte(input logic [23:0] old, input logic [1:0] k,
                                           input logic [7:0] d);
    logic [23:0] r;
    r = old;
    r[8*k +: 8] = d;
    return r;
  endfunction : put_byte

  assign idx = paddr[ADDR_W-1:2];
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_q;
  assign ctl_wr = wr_en && (idx == IDX_CONTROL);
  assign start_cmd = ctl_wr && pwdata[CTL_START] && pwdata[CTL_ENABLE];
  assign abort_cmd = ctl_wr && !start_cmd && (state_q == ST_RUN);
  assign analog_setup = analog_q;
  assign slow_osc_select = ctrl_q.clk_choice[1];
  assign analog_pin_enable = ctrl_q.enable;
  assign current_double = analog_q.random_en && prbs_q[0];
  assign touch_irq = irq_flag_q && ctrl_q.irq_en;
  assign wake_event = wake_q;
  assign width_mask = ctrl_q.auto_mode ? AUTO_MASK : {VAL_W{1'b1}};

  // The sensing oscillator is asynchronous; one edge is one charge cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_sync_q <= 2'b00;
      sense_last_q <= 1'b0;
    end else begin
      sense_sync_q <= {sense_sync_q[0], sense_osc};
      sense_last_q <= sense_sync_q[1];
    end
  end
  assign sense_tick = sense_sync_q[1] && !sense_last_q;

  // The block runs on the selected internal clock, so pclk is the internal tick.
  assign timer_tick = ctrl_q.mode ? 1'b1 : sense_tick;
  assign count_tick = ctrl_q.mode ? sense_tick : 1'b1;
  // An expiry that meets a control write is dropped; the write's start or abort takes over.
  assign expire = (state_q == ST_RUN) && timer_tick && (timer_q <= 24'h000001) && !ctl_wr;

  // Moving averages with truncating shifts and 32-bit sums.
  always_comb begin
    logic [31:0] sum;
    int sh;
    sum = 32'h0;
    sh = 0;
    new_slow = slow_q;
    new_fast = fast_q;
    if (filter_q[7:4] == 4'h0) begin
      new_slow = counter_q;
    end else if (filter_q[7:4] <= 4'h4) begin
      sh = SLOW_SHIFT_BASE + int'(filter_q[7:4]);
      sum = {8'h00, counter_q} + ({8'h00, slow_q} << sh) - {8'h00, slow_q};
      new_slow = VAL_W'(sum >> sh);
    end
    if (filter_q[3:0] == 4'h0) begin
      new_fast = counter_q;
    end else if (filter_q[3:0] <= 4'h4) begin
      sh = int'(filter_q[3:0]);
      sum = {8'h00, counter_q} + ({8'h00, fast_q} << sh) - {8'h00, fast_q};
      new_fast = VAL_W'(sum >> sh);
    end
    new_slow = new_slow & width_mask;
    new_fast = new_fast & width_mask;
  end

  // Detection threshold and settle delay.
  always_comb begin
    logic [33:0] prod;
    prod = {10'h000, slow_q} * {24'h000000, thresh_q[9:0]};
    // Bit 21 also carries the delay code, so an absolute threshold grows with delay codes 01 and 11 (256 and 1024).
    if (thresh_q[THR_ABS]) begin
      thr_val = {2'b00, thresh_q[21:0]};
    end else begin
      thr_val = VAL_W'(prod >> RATIO_SHIFT);
    end
    unique case (thresh_q[THR_DLY_LO +: 2])
      2'b00: delay_need = DELAY_64;
      2'b01: delay_need = DELAY_256;
      2'b10: delay_need = DELAY_512;
      2'b11: delay_need = DELAY_1024;
    endcase
  end
  assign detect = (state_q == ST_RUN) && ctrl_q.auto_mode && (settle_q >= delay_need) &&
                  ({1'b0, fast_q} > ({1'b0, slow_q} + {1'b0, thr_val}));

  // Capture sequencer.
  // A start written in the cycle of a detection restarts the capture instead of stopping it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else if (start_cmd) begin
      state_q <= ST_RUN;
    end else if (abort_cmd || !ctrl_q.enable) begin
      state_q <= ST_IDLE;
    end else if (detect) begin
      state_q <= ST_IDLE;
    end else if (expire && !ctrl_q.auto_mode) begin
      state_q <= ST_IDLE;
    end
  end

  // Timer and counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= '0;
      counter_q <= '0;
    end else if (start_cmd || (expire && ctrl_q.auto_mode)) begin
      timer_q <= period_q & (pwdata[CTL_AUTO] || !start_cmd ? AUTO_MASK : {VAL_W{1'b1}});
      counter_q <= '0;
    end else if (state_q == ST_RUN) begin
      if (timer_tick) begin
        timer_q <= (timer_q - 24'h000001) & width_mask;
      end
      if (count_tick) begin
        counter_q <= (counter_q + 24'h000001) & width_mask;
      end
    end
  end

  // Capture value, averages and settle count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= '0;
      slow_q <= '0;
      fast_q <= '0;
      settle_q <= '0;
    end else begin
      if (expire) begin
        capture_q <= counter_q & width_mask;
        slow_q <= new_slow;
        fast_q <= new_fast;
        if (settle_q != DELAY_1024) begin
          settle_q <= settle_q + 11'h001;
        end
      end else if (wr_en && idx >= IDX_SLOW && idx <= IDX_SLOW + 18'h2) begin
        slow_q <= put_byte(slow_q, 2'(idx - IDX_SLOW), pwdata[7:0]);
      end else if (wr_en && idx >= IDX_FAST && idx <= IDX_FAST + 18'h2) begin
        fast_q <= put_byte(fast_q, 2'(idx - IDX_FAST), pwdata[7:0]);
      end
      if (start_cmd) begin
        settle_q <= '0;
      end
    end
  end

  // Touch flag: a detection set wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= detect;
      if ((expire && !ctrl_q.auto_mode) || detect) begin
        irq_flag_q <= 1'b1;
      end else if (ctl_wr && !pwdata[CTL_FLAG]) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // Pseudo-random current selection, advanced once per charge cycle.
  // The non-zero seed keeps the register out of its all-zero lock-up state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prbs_q <= PRBS_SEED;
    end else if (analog_q.random_en && sense_tick) begin
      prbs_q <= {prbs_q[6:0], prbs_q[7] ^ prbs_q[5] ^ prbs_q[4] ^ prbs_q[3]};
    end
  end

  // Software configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_t'(CONTROL_RESET[7:2]);
      analog_q <= analog_t'({ANALOG_RESET[7:6], ANALOG_RESET[4:0]});
      filter_q <= FILTER_RESET;
      thresh_q <= '0;
      period_q <= '0;
    end else if (wr_en) begin
      if (idx == IDX_CONTROL) begin
        ctrl_q <= ctrl_t'(pwdata[7:2]);
      end
      if (idx == IDX_ANALOG) begin
        analog_q <= analog_t'({pwdata[7:6], pwdata[4:0]});
      end
      if (idx == IDX_FILTER) begin
        filter_q <= pwdata[7:0];
      end
      if (idx >= IDX_THRESH && idx <= IDX_THRESH + 18'h2) begin
        thresh_q <= put_byte(thresh_q, 2'(idx - IDX_THRESH), pwdata[7:0]);
      end
      if (idx >= IDX_PERIOD && idx <= IDX_PERIOD + 18'h2) begin
        period_q <= put_byte(period_q, 2'(idx - IDX_PERIOD), pwdata[7:0]);
      end
    end
  end

  // Read data is prepared in the setup phase and held through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= '0;
      if (idx == IDX_CONTROL) begin
        prdata_q[7:0] <= {ctrl_q, irq_flag_q, state_q == ST_RUN};
      end else if (idx == IDX_ANALOG) begin
        prdata_q[7:0] <= {analog_q[6:5], 1'b0, analog_q[4:0]};
      end else if (idx == IDX_FILTER) begin
        prdata_q[7:0] <= filter_q;
      end else if (idx >= IDX_THRESH && idx <= IDX_THRESH + 18'h2) begin
        prdata_q[7:0] <= thresh_q[8*(idx - IDX_THRESH) +: 8];
      end else if (idx >= IDX_PERIOD && idx <= IDX_PERIOD + 18'h2) begin
        prdata_q[7:0] <= period_q[8*(idx - IDX_PERIOD) +: 8];
      end else if (idx >= IDX_CAPTURE && idx <= IDX_CAPTURE + 18'h2) begin
        prdata_q[7:0] <= capture_q[8*(idx - IDX_CAPTURE) +: 8];
      end else if (idx >= IDX_SLOW && idx <= IDX_SLOW + 18'h2) begin
        prdata_q[7:0] <= slow_q[8*(idx - IDX_SLOW) +: 8];
      end else if (idx >= IDX_FAST && idx <= IDX_FAST + 18'h2) begin
        prdata_q[7:0] <= fast_q[8*(idx - IDX_FAST) +: 8];
      end
    end
  end

  chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl_wr && !pwdata[CTL_FLAG] && !detect) |=> !irq_flag_q && !touch_irq)
    else $error("flag not cleared");
  chk_start_loads: assert property (@(posedge pclk) disable iff (!presetn)
    start_cmd |=> (state_q == ST_RUN) && (counter_q == '0)) else $error("start bad");
  chk_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
    abort_cmd |=> state_q == ST_IDLE) else $error("abort failed");
  chk_capture_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && !ctrl_q.auto_mode) |=> capture_q == $past(counter_q) && irq_flag_q)
    else $error("capture not latched");
  chk_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && !ctrl_q.auto_mode && !detect) |=> state_q == ST_IDLE)
    else $error("single capture kept running");
  chk_auto_repeat: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && ctrl_q.auto_mode && !detect && ctrl_q.enable) |=> state_q == ST_RUN)
    else $error("auto mode stopped");
  chk_auto_width: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.auto_mode && state_q == ST_RUN && !$past(start_cmd)) |->
    counter_q[23:16] == 8'h00) else $error("auto count too wide");
  chk_prbs_live: assert property (@(posedge pclk) disable iff (!presetn)
    prbs_q != 8'h00) else $error("sequence stuck");
  chk_fast_raw: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && filter_q[3:0] == 4'h0) |=> fast_q == ($past(counter_q) & $past(width_mask)))
    else $error("fast raw wrong");
  chk_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_RUN && !ctrl_q.mode && !sense_tick && !start_cmd && !expire) |=>
    $stable(timer_q)) else $error("timer moved without sense edge");
  chk_wake_after: assert property (@(posedge pclk) disable iff (!presetn)
    (detect && !start_cmd) |=> wake_event && irq_flag_q && state_q == ST_IDLE)
    else $error("wake missing");
  chk_settle_count: assert property (@(posedge pclk) disable iff (!presetn)
    (expire && !start_cmd && settle_q != DELAY_1024) |=> settle_q == $past(settle_q) + 11'h001)
    else $error("settle count not advanced");
endmodule : touch_key_capacitance_sensor

// *** verification/sense_osc_model.sv ***
`timescale 1ns/1ps
// Stands in for the key's relaxation oscillator; double current halves the charge time when half is above 1.
module sense_osc_model (
  // Clock.
  input wire logic pclk,
  // Front-end control.
  input wire logic run,
  input wire logic [3:0] half,
  input wire logic double_current,
  // Oscillator output.
  output logic sense_osc
);
  logic [3:0] cnt_q;
  logic [3:0] lim;
  assign lim = (double_current && half > 4'h1) ? half >> 1 : half;
  initial begin
    sense_osc = 1'b0;
    cnt_q = 4'h0;
  end
  // The oscillator stops low while the analog pins are disabled.
  always @(posedge pclk) begin
    if (!run) begin
      sense_osc <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q + 4'h1 >= lim) begin
      sense_osc <= ~sense_osc;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : sense_osc_model

// *** verification/test_touch_key_capacitance_sensor.sv ***
`timescale 1ns/1ps
module test_touch_key_capacitance_sensor;
  import touch_key_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd, cap, val;
  logic pready, pslverr, sense_osc, current_double, slow_osc_select, analog_pin_enable;
  logic touch_irq, wake_event, cd_q;
  analog_t analog_setup;
  logic [3:0] half = 4'h2;
  int n_fail = 0;
  int checked = 0;
  int wakes = 0;
  int rises = 0;
  int fo, so, w0, r0;

  always #2.5 pclk = ~pclk;

  touch_key_capacitance_sensor touch_key_capacitance_sensor_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_osc(sense_osc),
    .analog_setup(analog_setup), .current_double(current_double),
    .slow_osc_select(slow_osc_select), .analog_pin_enable(analog_pin_enable),
    .touch_irq(touch_irq), .wake_event(wake_event));

  sense_osc_model sense_osc_model_i (.pclk(pclk), .run(analog_pin_enable), .half(half),
    .double_current(current_double), .sense_osc(sense_osc));

  always @(posedge pclk) begin
    cd_q <= current_double;
    if (wake_event === 1'b1) wakes <= wakes + 1;
    if (current_double === 1'b1 && cd_q === 1'b0) rises <= rises + 1;
  end

  task automatic xfer(input logic wr, input logic [17:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr24(input logic [17:0] idx, input logic [23:0] v);
    for (int i = 0; i < 3; i++) xfer(1'b1, idx + 18'(i), v[8*i+:8]);
  endtask : wr24

  task automatic rd24(input logic [17:0] idx);
    val = '0;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, idx + 18'(i), 8'h00);
      val[8*i+:8] = rd[7:0];
    end
  endtask : rd24

  task automatic wait_idle();
    rd = 32'h1;
    for (int n = 0; n < 40000 && rd[CTL_START] !== 1'b0; n++) xfer(1'b0, IDX_CONTROL, 8'h00);
  endtask : wait_idle

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, IDX_CONTROL + 18'(i), 8'h00);
      check("reset", rd, 32'h0);
    end
    xfer(1'b1, 18'h0a150, 8'h5a);
    xfer(1'b0, 18'h0a150, 8'h00);
    check("unmapped", {rd[30:0], pslverr}, 32'h0);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, IDX_CONTROL, {2'b10, c[1:0], 4'h0});
      @(posedge pclk);
      check("clk_choice", {slow_osc_select, analog_pin_enable}, {c[1], 1'b1});
    end
    xfer(1'b1, IDX_ANALOG, 8'hff);
    xfer(1'b0, IDX_ANALOG, 8'h00);
    check("analog_rd", rd, 32'h000000df);
    check("analog_out", {25'h0, analog_setup}, 32'h0000007f);
    xfer(1'b1, IDX_ANALOG, 8'h0f);
    $display("test registers done");
    wr24(IDX_PERIOD, 24'd200);
    for (int k = 0; k < 6; k++) begin
      wr24(IDX_FAST, 24'd80);
      wr24(IDX_SLOW, 24'd30);
      xfer(1'b1, IDX_FILTER, {k[3:0], k[3:0]});
      xfer(1'b1, IDX_CONTROL, 8'hc5);
      xfer(1'b0, IDX_CONTROL, 8'h00);
      check("busy", rd[1:0], 2'b01);
      wait_idle();
      rd24(IDX_CAPTURE);
      cap = val;
      check("cap_range", 32'(cap >= 48 && cap <= 52), 32'h1);
      fo = k == 0 ? cap : k == 5 ? 80 : (80 * ((1 << k) - 1) + cap) >> k;
      so = k == 0 ? cap : k == 5 ? 30 : (cap + 30 * ((8 << k) - 1)) >> (k + 3);
      rd24(IDX_FAST);
      check("fast", val, fo);
      rd24(IDX_SLOW);
      check("slow", val, so);
      check("irq", touch_irq, 1'b1);
      xfer(1'b1, IDX_CONTROL, 8'hc4);
      @(posedge pclk);
      check("irq_clr", touch_irq, 1'b0);
    end
    $display("test filters done");
    r0 = rises;
    xfer(1'b1, IDX_ANALOG, 8'hcf);
    xfer(1'b1, IDX_CONTROL, 8'hc1);
    wait_idle();
    check("prbs", 32'(rises > r0), 32'h1);
    check("flag_set", rd[1:0], 2'b10);
    check("irq_gated", touch_irq, 1'b0);
    xfer(1'b1, IDX_ANALOG, 8'h0f);
    @(posedge pclk);
    check("cd_off", current_double, 1'b0);
    wr24(IDX_PERIOD, 24'h00ffff);
    xfer(1'b1, IDX_CONTROL, 8'hc1);
    xfer(1'b1, IDX_CONTROL, 8'hc0);
    xfer(1'b0, IDX_CONTROL, 8'h00);
    check("abort", rd[1:0], 2'b00);
    $display("test abort done");
    wr24(IDX_PERIOD, 24'h004008);
    xfer(1'b1, IDX_CONTROL, 8'h81);
    wait_idle();
    rd24(IDX_CAPTURE);
    check("wide", 32'(val >= 65560 && val <= 65576), 32'h1);
    xfer(1'b1, IDX_CONTROL, 8'hc0);
    $display("test wide done");
    half <= 4'h1;
    wr24(IDX_FAST, 24'd10);
    wr24(IDX_SLOW, 24'd10);
    xfer(1'b1, IDX_FILTER, 8'h40);
    wr24(IDX_THRESH, 24'h800003);
    wr24(IDX_PERIOD, 24'h010028);
    w0 = wakes;
    xfer(1'b1, IDX_CONTROL, 8'hcd);
    repeat (2400) @(posedge pclk);
    xfer(1'b0, IDX_CONTROL, 8'h00);
    check("auto_run", {rd[1:0], touch_irq}, 3'b010);
    check("early_wake", wakes - w0, 0);
    for (int n = 0; n < 2000 && wakes == w0; n++) @(posedge pclk);
    check("wake", wakes - w0, 1);
    repeat (4) @(posedge pclk);
    xfer(1'b0, IDX_CONTROL, 8'h00);
    check("auto_stop", rd[1:0], 2'b10);
    rd24(IDX_CAPTURE);
    check("auto_cap", 32'(val >= 16 && val <= 24), 32'h1);
    $display("test auto done");
    wr24(IDX_FAST, 24'd10);
    wr24(IDX_SLOW, 24'd10);
    wr24(IDX_THRESH, 24'h000200);
    w0 = wakes;
    xfer(1'b1, IDX_CONTROL, 8'hcd);
    repeat (2400) @(posedge pclk);
    check("ratio_early", wakes - w0, 0);
    for (int n = 0; n < 2000 && wakes == w0; n++) @(posedge pclk);
    check("ratio_wake", wakes - w0, 1);
    $display("test ratio done");
    give_verdict();
  end
endmodule : test_touch_key_capacitance_sensor
